//--- logic/gpcp_pkg.sv
// constants for the 8-bit general port with change detection
//------------------------------------------------------------
// Notes on behaviour
// (R1) eight-bit bidirectional port, each pin steered by its own direction bit
// (R2) direction 0 drives pin from latch; 1 makes it an input read back
// (R3) clearing bit 7 of second_irq_control enables all eight weak pull-ups
// (R4) a pin set as output never has its weak pull-up on
// (R5) power-on reset leaves all weak pull-ups disabled
// (R6) only pins 7..4 are compared, and only those set as inputs
// (R7) input pins compared to snapshot taken at last port register read
// (R8) four mismatches ORed set port_change_flag, bit 0 of main_irq_control
// (R9) the port change interrupt can wake the device from low power
// (R10) any port register access refreshes snapshot, except a move source read
// (R11) mismatch keeps setting the flag; clearing works only after refresh
// (R12) software should not poll the port while change detection is used
// (R13) on 80-pin extended mode, alt map bit clear puts unit two on pin 3
// (R14) software sets pin 3 direction to suit capture or compare use
// (R15) pins 1..5 can carry parallel port address; pin 1 bit 4, 2 bit 3
// (R16) input pins 0..3 feed external interrupt inputs 0..3
// (R17) input pin 0 feeds unit one pwm fault input when software enables it
// (R18) active unit two compare or pwm output overrides port latch data
// (R19) pins 4 and 5 carry address bits 1 and 0; 7..4 are key inputs
// (R20) in serial programming mode pins 6 and 7 serve only that use
// (R21) any reset makes every pin an input and reinitialises the snapshot
// (R22) port or latch writes load latch; latch reads return latch contents
//------------------------------------------------------------
package gpcp_pkg;

  // register byte offsets
  localparam logic [7:0] GPCP_OFF_PORT = 8'h00;
  localparam logic [7:0] GPCP_OFF_LAT = 8'h04;
  localparam logic [7:0] GPCP_OFF_DIR = 8'h08;
  localparam logic [7:0] GPCP_OFF_MAIN_IRQ = 8'h0C;
  localparam logic [7:0] GPCP_OFF_SECOND_IRQ = 8'h10;
  localparam logic [7:0] GPCP_OFF_CFG = 8'h14;

  // field positions
  localparam int GPCP_BIT_CHG_FLAG = 0;
  localparam int GPCP_BIT_CHG_EN = 3;
  localparam int GPCP_BIT_PULLUPS_OFF_N = 7;
  localparam int GPCP_BIT_ALT_MAP = 0;
  localparam int GPCP_BIT_EXT_MODE = 1;
  localparam int GPCP_BIT_FAULT_EN = 2;
  localparam int GPCP_PMP_EN_LSB = 4;
  localparam int GPCP_PMP_PINS = 5;
  localparam int GPCP_CHG_LSB = 4;
  localparam int GPCP_CHG_PINS = 4;
  localparam int GPCP_PIN_ALT_CCP = 3;
  localparam int GPCP_PIN_PROG_CLK = 6;
  localparam int GPCP_PIN_PROG_DAT = 7;
  localparam int GPCP_PIN_FAULT = 0;
  localparam int GPCP_EXT_IRQS = 4;

  // values after reset
  localparam logic [7:0] GPCP_RST_DIR = 8'hFF;
  localparam logic [7:0] GPCP_RST_LAT = 8'h00;
  localparam logic GPCP_RST_PULLUPS_OFF_N = 1'b1;
  localparam logic GPCP_RST_ALT_MAP = 1'b1;

endpackage

//--- logic/gpcp_change_det.sv
// change detector comparing input pins against a snapshot
`timescale 1ns/1ps
`default_nettype none
module gpcp_change_det #(
  parameter int W = 4
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] pins, // current pin levels
  input wire logic [W-1:0] is_input, // 1 where pin is an input
  input wire logic refresh, // port access, retake snapshot
  output logic mismatch // any input differs from snapshot
);
  logic [W-1:0] snap_r;
  logic snap_valid_r;
  logic [W-1:0] diff;

  // ------------------------------------------------------------
  // snapshot
  // ------------------------------------------------------------
  // reset cannot load a port value, so the first clock after it
  // captures the pins instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_r <= '0; // [R21]
      snap_valid_r <= 1'b0;
    end else if (refresh || !snap_valid_r) begin
      snap_r <= pins; // [R10]
      snap_valid_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // comparison
  // ------------------------------------------------------------
  // outputs are masked out of the compare
  assign diff = (pins ^ snap_r) & is_input; // [R6] [R7]
  assign mismatch = snap_valid_r && (|diff); // [R8]
endmodule
`default_nettype wire

//--- logic/gpcp_port.sv
// 8-bit general port with change flag and pin sharing, apb slave
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module gpcp_port #(
  parameter bit PIN80 = 1'b1 // part has the alternate pin mapping
) (
  input wire logic pclk, // system clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, 1 write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic move_src, // read is a memory move source
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [7:0] pin_in, // pad input levels
  output logic [7:0] pin_out, // pad output levels
  output logic [7:0] pin_oe, // pad output enables, 1 drives
  output logic [7:0] pullup_en, // weak pull-up enables
  input wire logic [4:0] pmp_addr, // parallel port address 4..0
  input wire logic ccp2_active, // unit two compare/pwm running
  input wire logic ccp2_out, // unit two output level
  output logic ccp2_in, // unit two capture input
  input wire logic prog_mode, // serial programming enabled
  input wire logic prog_data_out, // programming data to pad
  input wire logic prog_data_oe, // programming drives data pad
  output logic prog_clock_in, // programming clock from pad
  output logic prog_data_in, // programming data from pad
  output logic [3:0] ext_irq_in, // external interrupt inputs 0..3
  output logic pwm_fault_in, // unit one fault input
  output logic [3:0] key_change_in, // key inputs on pins 4..7
  output logic port_change_flag, // change flag level
  output logic wake // wake request from low power
);
  import gpcp_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [7:0] dir_r;
  logic [7:0] lat_r;
  logic chg_flag_r;
  logic chg_en_r;
  logic pullups_off_n_r;
  logic alt_map_r;
  logic ext_mode_r;
  logic fault_en_r;
  logic [GPCP_PMP_PINS-1:0] pmp_en_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic pready_r;
  logic pslverr_r;
  logic setup;
  logic access;
  logic wr_go;
  logic rd_go;
  logic mapped;
  logic port_hit;
  logic refresh;
  logic mismatch;
  logic alt_ccp_on;
  logic [7:0] out_nxt;
  logic [7:0] oe_nxt;
  logic [7:0] pin_out_r;
  logic [7:0] pin_oe_r;
  logic [7:0] pullup_r;
  logic [3:0] ext_irq_r;
  logic [3:0] key_r;
  logic fault_r;
  logic ccp2_in_r;
  logic prog_clk_r;
  logic prog_dat_r;
  logic wake_r;
  logic [7:0] pmp_map;

  // ------------------------------------------------------------
  // apb handshake
  // ------------------------------------------------------------
  // no wait state: ready rises in the first access cycle, so the
  // read mux settles from the setup cycle's pin levels
  assign setup = psel && !penable;
  assign access = psel && penable && pready_r;
  assign wr_go = access && pwrite;
  assign rd_go = access && !pwrite;

  // address decode
  always_comb begin
    unique case (paddr)
      GPCP_OFF_PORT, GPCP_OFF_LAT, GPCP_OFF_DIR,
      GPCP_OFF_MAIN_IRQ, GPCP_OFF_SECOND_IRQ, GPCP_OFF_CFG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read mux; reserved bits read zero
  always_comb begin
    rd_nxt = '0;
    unique case (paddr)
      GPCP_OFF_PORT: rd_nxt[7:0] = pin_in; // [R2]
      GPCP_OFF_LAT: rd_nxt[7:0] = lat_r; // [R22]
      GPCP_OFF_DIR: rd_nxt[7:0] = dir_r; // [R1]
      GPCP_OFF_MAIN_IRQ: begin
        rd_nxt[GPCP_BIT_CHG_FLAG] = chg_flag_r;
        rd_nxt[GPCP_BIT_CHG_EN] = chg_en_r;
      end
      GPCP_OFF_SECOND_IRQ: rd_nxt[GPCP_BIT_PULLUPS_OFF_N] = pullups_off_n_r;
      GPCP_OFF_CFG: begin
        rd_nxt[GPCP_BIT_ALT_MAP] = alt_map_r;
        rd_nxt[GPCP_BIT_EXT_MODE] = ext_mode_r;
        rd_nxt[GPCP_BIT_FAULT_EN] = fault_en_r;
        rd_nxt[GPCP_PMP_EN_LSB +: GPCP_PMP_PINS] = pmp_en_r;
      end
      default: rd_nxt = '0;
    endcase
  end

  // ready, data and error from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pready_r <= 1'b1;
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= !mapped;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // port registers
  // ------------------------------------------------------------
  assign port_hit = access && (paddr == GPCP_OFF_PORT);

  // direction resets to all inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= GPCP_RST_DIR; // [R21]
    end else if (wr_go && paddr == GPCP_OFF_DIR) begin
      dir_r <= pwdata[7:0]; // [R1]
    end
  end

  // both the port and latch addresses write the latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_r <= GPCP_RST_LAT;
    end else if (wr_go && (paddr == GPCP_OFF_PORT
                           || paddr == GPCP_OFF_LAT)) begin
      lat_r <= pwdata[7:0]; // [R22]
    end
  end

  // shared pull-up control, off after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullups_off_n_r <= GPCP_RST_PULLUPS_OFF_N; // [R5]
    end else if (wr_go && paddr == GPCP_OFF_SECOND_IRQ) begin
      pullups_off_n_r <= pwdata[GPCP_BIT_PULLUPS_OFF_N]; // [R3]
    end
  end

  // pin sharing configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_map_r <= GPCP_RST_ALT_MAP;
      ext_mode_r <= 1'b0;
      fault_en_r <= 1'b0;
      pmp_en_r <= '0;
    end else if (wr_go && paddr == GPCP_OFF_CFG) begin
      alt_map_r <= pwdata[GPCP_BIT_ALT_MAP];
      ext_mode_r <= pwdata[GPCP_BIT_EXT_MODE];
      fault_en_r <= pwdata[GPCP_BIT_FAULT_EN]; // [R17]
      pmp_en_r <= pwdata[GPCP_PMP_EN_LSB +: GPCP_PMP_PINS]; // [R15]
    end
  end

  // ------------------------------------------------------------
  // change detection
  // ------------------------------------------------------------
  // a move that only names the port as its source leaves the
  // snapshot alone; polling reads will hide changes
  assign refresh = port_hit && (pwrite || !move_src); // [R10] [R12]

  gpcp_change_det #(
    .W(GPCP_CHG_PINS)
  ) u_chg (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pin_in[GPCP_CHG_LSB +: GPCP_CHG_PINS]),
    .is_input((dir_r[GPCP_CHG_LSB +: GPCP_CHG_PINS] &
               ~{GPCP_CHG_PINS{prog_mode}}) |
              (dir_r[GPCP_CHG_LSB +: GPCP_CHG_PINS] & 4'h3)), // [R20]
    .refresh(refresh),
    .mismatch(mismatch)
  );

  // flag: mismatch sets and wins over a software clear, so a
  // clear only sticks once a port access ends the mismatch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_flag_r <= 1'b0;
      chg_en_r <= 1'b0;
    end else begin
      if (mismatch) begin
        chg_flag_r <= 1'b1; // [R8] [R11]
      end else if (wr_go && paddr == GPCP_OFF_MAIN_IRQ) begin
        chg_flag_r <= pwdata[GPCP_BIT_CHG_FLAG]; // [R11]
      end
      if (wr_go && paddr == GPCP_OFF_MAIN_IRQ) begin
        chg_en_r <= pwdata[GPCP_BIT_CHG_EN];
      end
    end
  end

  // wake runs off the flag, needs no clock gating knowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= chg_flag_r && chg_en_r; // [R9]
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  // address lines land reversed: pin 1 carries bit 4, pin 5 bit 0
  assign pmp_map = {2'b00, pmp_addr[0], pmp_addr[1], pmp_addr[2],
                    pmp_addr[3], pmp_addr[4], 1'b0}; // [R15] [R19]

  assign alt_ccp_on = PIN80 && ext_mode_r && !alt_map_r; // [R13]

  // priority: programming, parallel address, unit two, latch
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      always_comb begin
        out_nxt[gi] = lat_r[gi]; // [R2]
        oe_nxt[gi] = !dir_r[gi]; // [R2]
        if (prog_mode && gi == GPCP_PIN_PROG_CLK) begin
          out_nxt[gi] = 1'b0; // [R20]
          oe_nxt[gi] = 1'b0;
        end else if (prog_mode && gi == GPCP_PIN_PROG_DAT) begin
          out_nxt[gi] = prog_data_out; // [R20]
          oe_nxt[gi] = prog_data_oe;
        end else if (gi >= 1 && gi <= GPCP_PMP_PINS
                     && pmp_en_r[(gi >= 1 && gi <= GPCP_PMP_PINS) ?
                                 gi - 1 : 0]) begin
          out_nxt[gi] = pmp_map[gi]; // [R15]
          oe_nxt[gi] = 1'b1; // direction ignored
        end else if (gi == GPCP_PIN_ALT_CCP && alt_ccp_on
                     && ccp2_active && !dir_r[gi]) begin
          out_nxt[gi] = ccp2_out; // [R18] [R14]
          oe_nxt[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // pad registers; pull-up dropped on any driving pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
      pullup_r <= '0; // [R5]
    end else begin
      pin_out_r <= out_nxt;
      pin_oe_r <= oe_nxt;
      pullup_r <= ~oe_nxt & {8{!pullups_off_n_r}}; // [R3] [R4]
    end
  end

  // ------------------------------------------------------------
  // inputs to other units
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_r <= '0;
      fault_r <= 1'b0;
      key_r <= '0;
      ccp2_in_r <= 1'b0;
      prog_clk_r <= 1'b0;
      prog_dat_r <= 1'b0;
    end else begin
      // only input pins feed the interrupt lines
      ext_irq_r <= pin_in[3:0] & dir_r[3:0]; // [R16]
      fault_r <= pin_in[GPCP_PIN_FAULT] && dir_r[GPCP_PIN_FAULT]
                 && fault_en_r; // [R17]
      key_r <= pin_in[7:4] & dir_r[7:4]
               & {!prog_mode, !prog_mode, 2'b11}; // [R19] [R20]
      ccp2_in_r <= alt_ccp_on && dir_r[GPCP_PIN_ALT_CCP]
                   && pin_in[GPCP_PIN_ALT_CCP]; // [R13]
      prog_clk_r <= prog_mode && pin_in[GPCP_PIN_PROG_CLK]; // [R20]
      prog_dat_r <= prog_mode && pin_in[GPCP_PIN_PROG_DAT];
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign pullup_en = pullup_r;
  assign ext_irq_in = ext_irq_r;
  assign pwm_fault_in = fault_r;
  assign key_change_in = key_r;
  assign ccp2_in = ccp2_in_r;
  assign prog_clock_in = prog_clk_r;
  assign prog_data_in = prog_dat_r;
  assign port_change_flag = chg_flag_r;
  assign wake = wake_r;
endmodule
`default_nettype wire

//--- tb/gpcp_board.sv
// board-side model of the eight port pads
`timescale 1ns/1ps
`default_nettype none
module gpcp_board (
  input wire logic [7:0] pin_out, // device pad drive
  input wire logic [7:0] pin_oe, // device drives when high
  input wire logic [7:0] pullup_en, // device weak pull-ups
  input wire logic [7:0] ext_val, // board drive level
  input wire logic [7:0] ext_oe, // board drives when high
  output logic [7:0] pin_in // resolved pad level
);
  //------------------------------------------------------------
  // pad resolution
  //------------------------------------------------------------
  // a floating pad shows the inverse of the board level, so a
  // missing pull-up cannot pass by luck
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_oe[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pullup_en[i]) begin
        pin_in[i] = 1'h1;
      end else begin
        pin_in[i] = ~ext_val[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/gpcp_port_chk.sv
// assertions on the port block's pins and change flag
`timescale 1ns/1ps
`default_nettype none
module gpcp_port_chk
  import gpcp_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [7:0] pin_in, // pad levels
  input wire logic [7:0] pin_oe, // pad enables
  input wire logic [7:0] pullup_en, // weak pull-ups
  input wire logic prog_mode, // programming mode
  input wire logic prog_clock_in, // programming clock
  input wire logic [3:0] ext_irq_in, // external irq inputs
  input wire logic [3:0] key_change_in, // key inputs
  input wire logic port_change_flag, // change flag
  input wire logic wake // wake request
);
  //------------------------------------------------------------
  // pin and flag properties
  //------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pin path may take two registers, hence three stable samples
  AST_PULL_OUT: assert property (
    !prog_mode |-> (pullup_en & pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  AST_PULL_POR: assert property (
    !$past(presetn) |=> pullup_en == 8'h00)
    else $error("pull-up on after reset");
  AST_ALL_IN: assert property (
    !$past(presetn) |=> pin_oe == 8'h00)
    else $error("pin driven after reset");
  AST_FLAG_HOLD: assert property (
    port_change_flag && !(psel && penable && pwrite &&
    paddr == GPCP_OFF_MAIN_IRQ) |=> port_change_flag)
    else $error("flag dropped without a write");
  AST_WAKE: assert property (
    wake |-> $past(port_change_flag))
    else $error("wake without flag");
  AST_EXT_IRQ: assert property (
    (pin_oe[3:0] == 4'h0 && $stable(pin_in[3:0]) && $stable(pin_oe))[*3]
    |-> ext_irq_in == pin_in[3:0])
    else $error("external irq input differs from pad");
  AST_KEY_IN: assert property (
    (pin_oe[7:4] == 4'h0 && !prog_mode && $stable(pin_in[7:4]))[*3]
    |-> key_change_in == pin_in[7:4])
    else $error("key input differs from pad");
  AST_PROG_MASK: assert property (
    prog_mode[*3] |-> key_change_in[3:2] == 2'h0)
    else $error("key input live in programming mode");
  AST_PROG_CLK: assert property (
    (prog_mode && $stable(pin_in[6]))[*3] |-> prog_clock_in == pin_in[6])
    else $error("programming clock differs from pad");
endmodule
bind gpcp_port gpcp_port_chk i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pin_in, .pin_oe, .pullup_en, .prog_mode,
  .prog_clock_in, .ext_irq_in, .key_change_in, .port_change_flag, .wake);
`default_nettype wire

//--- tb/test_gpio_port_with_change_irq.sv
// self-checking bench for the 8-bit port with change flag
`timescale 1ns/1ps
`default_nettype none
module test_gpio_port_with_change_irq;
  import gpcp_pkg::*;
  //------------------------------------------------------------
  // design, board and bus tasks
  //------------------------------------------------------------
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, move_src = 1'h0, ccp2_active = 1'h0, err;
  logic ccp2_out = 1'h0, prog_mode = 1'h0, prog_data_out = 1'h0;
  logic prog_data_oe = 1'h0, pready, pslverr, ccp2_in, prog_clock_in;
  logic prog_data_in, pwm_fault_in, port_change_flag, wake;
  logic [7:0] paddr = 8'h00, ext_val = 8'h5A, ext_oe = 8'hFF;
  logic [7:0] pin_in, pin_out, pin_oe, pullup_en;
  logic [4:0] pmp_addr = 5'h16;
  logic [3:0] ext_irq_in, key_change_in;
  logic [31:0] pwdata = 32'h0, rv, prdata;
  int bad_count = 0, tests_run = 0;
  // 25 MHz system clock
  always #20 pclk = ~pclk;
  gpcp_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .move_src, .prdata, .pready, .pslverr, .pin_in, .pin_out,
    .pin_oe, .pullup_en, .pmp_addr, .ccp2_active, .ccp2_out, .ccp2_in,
    .prog_mode, .prog_data_out, .prog_data_oe, .prog_clock_in,
    .prog_data_in, .ext_irq_in, .pwm_fault_in, .key_change_in,
    .port_change_flag, .wake);
  gpcp_board i_board (.pin_out, .pin_oe, .pullup_en, .ext_val, .ext_oe,
    .pin_in);
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // holds the request until pready is seen high, bounded
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      bad_count++;
      give_verdict();
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // outputs lag their cause by up to two registers
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge pclk);
    ext_val <= v;
  endtask
  task automatic flag_is(input logic f);
    settle();
    chk(port_change_flag, f);
  endtask
  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task automatic t_reset();
    chk(pullup_en, 8'h00);
    apb(1'h1, 8'h18, 32'h0);
    chk(err, 1'h1);
    apb(1'h0, 8'h18, 32'h0);
    chk(err, 1'h1);
    chk(rv, 32'h0);
    apb(1'h0, GPCP_OFF_DIR, 32'h0);
    chk(rv, 32'hFF);
    apb(1'h0, GPCP_OFF_SECOND_IRQ, 32'h0);
    chk(rv[7], 1'h1);
  endtask
  task automatic t_latch();
    apb(1'h1, GPCP_OFF_LAT, 32'hA5);
    apb(1'h1, GPCP_OFF_DIR, 32'h0F);
    settle();
    chk({pin_oe, pin_out[7:4]}, 12'hF0A);
    apb(1'h0, GPCP_OFF_PORT, 32'h0);
    chk(rv, {24'h0, 4'hA, ext_val[3:0]});
    apb(1'h1, GPCP_OFF_PORT, 32'h3C);
    apb(1'h0, GPCP_OFF_LAT, 32'h0);
    chk(rv, 32'h3C);
  endtask
  task automatic t_pull();
    ext_oe <= 8'hF0;
    apb(1'h1, GPCP_OFF_SECOND_IRQ, 32'h0);
    settle();
    chk(pullup_en, 8'h0F);
    apb(1'h0, GPCP_OFF_PORT, 32'h0);
    chk(rv, 32'h3F);
    apb(1'h1, GPCP_OFF_SECOND_IRQ, 32'h80);
    settle();
    chk(pullup_en, 8'h00);
    ext_oe <= 8'hFF;
  endtask
  // no port reads while waiting, a read would hide the change
  task automatic t_change();
    apb(1'h1, GPCP_OFF_DIR, 32'hFF);
    pins(8'h00);
    apb(1'h0, GPCP_OFF_PORT, 32'h0);
    apb(1'h1, GPCP_OFF_MAIN_IRQ, 32'h08);
    pins(8'h01);
    flag_is(1'h0);
    pins(8'h21);
    flag_is(1'h1);
    chk(wake, 1'h1);
    apb(1'h1, GPCP_OFF_MAIN_IRQ, 32'h08);
    flag_is(1'h1);
    move_src <= 1'h1;
    apb(1'h0, GPCP_OFF_PORT, 32'h0);
    move_src <= 1'h0;
    apb(1'h1, GPCP_OFF_MAIN_IRQ, 32'h08);
    flag_is(1'h1);
    apb(1'h0, GPCP_OFF_PORT, 32'h0);
    apb(1'h1, GPCP_OFF_MAIN_IRQ, 32'h08);
    flag_is(1'h0);
    apb(1'h1, GPCP_OFF_DIR, 32'hEF);
    apb(1'h0, GPCP_OFF_PORT, 32'h0);
    apb(1'h1, GPCP_OFF_MAIN_IRQ, 32'h08);
    apb(1'h1, GPCP_OFF_LAT, 32'h00);
    flag_is(1'h0);
  endtask
  task automatic t_pmp_ccp();
    apb(1'h1, GPCP_OFF_DIR, 32'hFF);
    apb(1'h1, GPCP_OFF_CFG, 32'h1F1);
    settle();
    chk(pin_oe[5:1], 5'h1F);
    for (int i = 0; i < 5; i++) begin
      chk(pin_out[i + 1], pmp_addr[4 - i]);
    end
    apb(1'h1, GPCP_OFF_DIR, 32'hF7);
    ccp2_active <= 1'h1;
    ccp2_out <= 1'h1;
    apb(1'h1, GPCP_OFF_CFG, 32'h02);
    settle();
    chk({pin_oe[3], pin_out[3]}, 2'h3);
    ccp2_out <= 1'h0;
    settle();
    chk(pin_out[3], 1'h0);
    apb(1'h1, GPCP_OFF_DIR, 32'hFF);
    pins(8'h08);
    settle();
    chk(ccp2_in, 1'h1);
    ccp2_active <= 1'h0;
  endtask
  task automatic t_irq_prog();
    apb(1'h1, GPCP_OFF_CFG, 32'h05);
    pins(8'hC9);
    settle();
    chk({ext_irq_in, pwm_fault_in, key_change_in}, 9'h13C);
    apb(1'h1, GPCP_OFF_DIR, 32'hF0);
    settle();
    chk({ext_irq_in, pwm_fault_in}, 5'h00);
    apb(1'h1, GPCP_OFF_DIR, 32'hFF);
    prog_mode <= 1'h1;
    prog_data_oe <= 1'h1;
    prog_data_out <= 1'h1;
    pins(8'h40);
    settle();
    chk({prog_clock_in, prog_data_in, key_change_in[3:2]}, 4'hC);
    chk({pin_oe[7], pin_out[7]}, 2'h3);
    prog_mode <= 1'h0;
  endtask
  // mid-run reset: all pins back to inputs, pull-ups off, and the
  // snapshot retaken so stale pin levels raise no flag
  task automatic t_rerst();
    apb(1'h1, GPCP_OFF_DIR, 32'h0F);
    apb(1'h1, GPCP_OFF_SECOND_IRQ, 32'h0);
    pins(8'h90);
    settle();
    chk(pullup_en, 8'h0F);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, GPCP_OFF_DIR, 32'h0);
    chk(rv, 32'hFF);
    chk({pin_oe, pullup_en}, 16'h0000);
    flag_is(1'h0);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_latch();
    t_pull();
    t_change();
    t_pmp_ccp();
    t_irq_prog();
    t_rerst();
    give_verdict();
  end
endmodule
`default_nettype wire
